// ===== core/usb_sr_defs.svh
/*
  timing counts, sizes and endpoint numbers for the usb suspend/resume block.
  assumes a 50 MHz bus clock; included by bare name.
*/
`ifndef USB_SR_DEFS_SVH
`define USB_SR_DEFS_SVH

`define CLK_PERIOD_NS     20
`define CLK_FREQ_MHZ      50
`define SUSPEND_IDLE_MS   3
`define SUSPEND_IDLE_CYC  (`SUSPEND_IDLE_MS * 1000 * `CLK_FREQ_MHZ)
`define BUS_RESET_NS      2500
`define BUS_RESET_CYC     ((`BUS_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W             18
`define EP_LAST           6
`define EP_PINGPONG_A     5
`define EP_PINGPONG_B     6
`define RAM_BYTES         256
`define RAM_AW            8

`endif

// ===== core/usb_sr_pkg.sv
/*
  types shared by the usb suspend/resume block and its line monitor.
  assumes usb_sr_defs.svh is compiled first.
*/
`include "usb_sr_defs.svh"

package usb_sr_pkg;

  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_WAIT,
    MODE_CLOCK_GATED_STOP,
    MODE_PARTIAL_POWER_STOP,
    MODE_POWER_OFF_STOP
  } power_mode_t;

  typedef enum logic [1:0] {
    LINE_SE0,
    LINE_J,
    LINE_K,
    LINE_SE1
  } line_state_t;

  typedef enum logic [1:0] {
    XFER_INTERRUPT,
    XFER_BULK,
    XFER_ISOCHRONOUS,
    XFER_CONTROL
  } xfer_type_t;

  typedef struct packed {
    logic       enable;
    logic       dir_in;
    xfer_type_t kind;
  } ep_cfg_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] ep;
    logic       dir_in;
  } token_t;

  typedef struct packed {
    logic                en;
    logic                we;
    logic [`RAM_AW-1:0]  addr;
    logic [7:0]          wdata;
  } ram_req_t;

endpackage

// ===== core/usb_line_monitor.sv
/*
  full-speed line monitor: decodes the data line pair, times bus idle and bus reset, flags end of packet.
  assumes the line inputs are synchronous to i_clk.
*/
`timescale 1ns/1ps
`include "usb_sr_defs.svh"

module usb_line_monitor #(
  parameter int unsigned IDLE_CYC = `SUSPEND_IDLE_CYC
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  input  wire logic                  i_dp,
  input  wire logic                  i_dm,
  input  wire logic                  i_active,
  output usb_sr_pkg::line_state_t    o_line,
  output logic                       o_idle_reached,
  output logic                       o_bus_reset,
  output logic                       o_eop
);

  localparam logic [`CNT_W-1:0] IDLE_LIM  = `CNT_W'(IDLE_CYC);
  localparam logic [`CNT_W-1:0] RESET_LIM = `CNT_W'(`BUS_RESET_CYC);

  usb_sr_pkg::line_state_t line;
  usb_sr_pkg::line_state_t next_line;
  logic [`CNT_W-1:0]       idle_cnt;
  logic [`CNT_W-1:0]       next_idle_cnt;
  logic [`CNT_W-1:0]       se0_cnt;
  logic [`CNT_W-1:0]       next_se0_cnt;
  logic                    next_eop;

  always_comb begin
    case ({i_dp, i_dm})
      2'b10:   next_line = usb_sr_pkg::LINE_J;
      2'b01:   next_line = usb_sr_pkg::LINE_K;
      2'b00:   next_line = usb_sr_pkg::LINE_SE0;
      default: next_line = usb_sr_pkg::LINE_SE1;
    endcase
    // idle is a steady J; the count saturates so the flag stays up
    if (!i_active || line != usb_sr_pkg::LINE_J)
      next_idle_cnt = '0;
    else if (idle_cnt != IDLE_LIM)
      next_idle_cnt = idle_cnt + `CNT_W'(1);
    else
      next_idle_cnt = idle_cnt;
    if (!i_active || line != usb_sr_pkg::LINE_SE0)
      next_se0_cnt = '0;
    else if (se0_cnt != RESET_LIM)
      next_se0_cnt = se0_cnt + `CNT_W'(1);
    else
      next_se0_cnt = se0_cnt;
    // short se0 followed by j closes a packet; a long se0 is a bus reset instead
    next_eop = i_active && line == usb_sr_pkg::LINE_SE0 && next_line == usb_sr_pkg::LINE_J
               && se0_cnt != RESET_LIM;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      // reset to the idle j so a release onto an idle bus gives no false end of packet
      line     <= usb_sr_pkg::LINE_J;
      idle_cnt <= '0;
      se0_cnt  <= '0;
      o_eop    <= 1'b0;
    end else begin
      line     <= next_line;
      idle_cnt <= next_idle_cnt;
      se0_cnt  <= next_se0_cnt;
      o_eop    <= next_eop;
    end
  end

  assign o_line         = line;
  assign o_idle_reached = (idle_cnt == IDLE_LIM);
  assign o_bus_reset    = (se0_cnt == RESET_LIM);

  a_idle_needs_j: assert property (@(posedge i_clk) disable iff (i_srst)
    o_idle_reached |-> $past(line) == usb_sr_pkg::LINE_J && $past(i_active))
    else $error("idle reached without a steady j");

  a_reset_needs_se0: assert property (@(posedge i_clk) disable iff (i_srst)
    $rose(o_bus_reset) |-> $past(line) == usb_sr_pkg::LINE_SE0 && $past(se0_cnt) == RESET_LIM - `CNT_W'(1))
    else $error("bus reset without full se0 time");

endmodule // usb_line_monitor

// ===== core/usb_suspend_resume.sv
/*
  usb device suspend/resume core: power mode gating, suspend and low-power resume flags, bus reset event,
  endpoint token screening, ping-pong buffer select and the shared buffer ram.
  assumes firmware drives the control inputs and the packet engine drives the token, transfer and ram requests.
*/
`timescale 1ns/1ps
`include "usb_sr_defs.svh"

module usb_suspend_resume #(
  parameter int unsigned SUSPEND_IDLE_CYC = `SUSPEND_IDLE_CYC
) (
  input  wire logic                                  I_CLK,
  input  wire logic                                  I_SRST,
  input  wire logic                                  i_MODULE_RESET,
  input  wire usb_sr_pkg::power_mode_t               i_POWER_MODE,
  input  wire logic                                  i_CLOCK_GATED_KEEP,
  input  wire logic                                  i_TRANSCEIVER_ENABLE,
  input  wire logic                                  i_REGULATOR_ENABLE,
  input  wire logic                                  i_RESUME_WAKE_ENABLE,
  input  wire logic                                  i_SUSPEND_CLEAR,
  input  wire logic                                  i_REMOTE_WAKE,
  input  wire logic                                  i_DATA_PLUS_LINE,
  input  wire logic                                  i_DATA_MINUS_LINE,
  output logic                                       o_DATA_PLUS_LINE,
  output logic                                       o_DATA_PLUS_LINE_OE,
  output logic                                       o_DATA_MINUS_LINE,
  output logic                                       o_DATA_MINUS_LINE_OE,
  output usb_sr_pkg::line_state_t                    o_LINE_STATE,
  output logic                                       o_EOP_SEEN,
  output logic                                       o_SUSPEND_IDLE_FLAG,
  output logic                                       o_LOWPOWER_RESUME_FLAG,
  output logic                                       o_WAKE_IRQ,
  output logic                                       o_CLOCK_REQUEST,
  output logic                                       o_BUS_RESET_IRQ,
  output logic                                       o_SHUTDOWN_FAULT,
  input  wire usb_sr_pkg::ep_cfg_t [`EP_LAST:1]      i_EP_CFG,
  input  wire usb_sr_pkg::token_t                    i_TOKEN,
  output logic                                       o_TOKEN_ACCEPT,
  output usb_sr_pkg::xfer_type_t                     o_TOKEN_TYPE,
  input  wire logic                                  i_XFER_DONE,
  input  wire logic [2:0]                            i_XFER_EP,
  output logic [1:0]                                 o_PINGPONG,
  input  wire usb_sr_pkg::ram_req_t                  i_CPU_RAM,
  output logic [7:0]                                 o_CPU_RDATA,
  input  wire usb_sr_pkg::ram_req_t                  i_SIE_RAM,
  output logic [7:0]                                 o_SIE_RDATA
);

  localparam logic [2:0] EP_A = 3'(`EP_PINGPONG_A);
  localparam logic [2:0] EP_B = 3'(`EP_PINGPONG_B);
  localparam logic [2:0] EP_N = 3'(`EP_LAST);

  logic                    functional;
  logic                    deep_stop;
  logic                    line_active;
  logic                    clr;
  usb_sr_pkg::line_state_t line;
  logic                    idle_reached;
  logic                    bus_reset;
  logic                    eop;
  logic                    idle_seen;
  logic                    next_idle_seen;
  logic                    reset_seen;
  logic                    next_reset_seen;
  logic                    suspend_flag;
  logic                    next_suspend_flag;
  logic                    resume_flag;
  logic                    next_resume_flag;
  logic                    k_meta;
  logic                    k_sync;
  logic                    bus_reset_irq;
  logic                    next_bus_reset_irq;
  logic                    shutdown_fault;
  logic                    next_shutdown_fault;
  logic [1:0]              pingpong;
  logic [1:0]              next_pingpong;
  usb_sr_pkg::xfer_type_t  token_type;
  usb_sr_pkg::xfer_type_t  next_token_type;
  logic [7:0]              ram [0:`RAM_BYTES-1];
  logic [7:0]              cpu_rdata;
  logic [7:0]              sie_rdata;

  // endpoint screening, used for the accept strobe and for the type it reports
  function automatic logic ep_allowed(input usb_sr_pkg::ep_cfg_t [`EP_LAST:1] cfg,
                                      input usb_sr_pkg::token_t tok);
    if (tok.ep == 3'h0)
      return 1'b1;
    else if (tok.ep > EP_N)
      return 1'b0;
    else
      return cfg[tok.ep].enable && (cfg[tok.ep].dir_in == tok.dir_in);
  endfunction

  function automatic usb_sr_pkg::xfer_type_t ep_kind(input usb_sr_pkg::ep_cfg_t [`EP_LAST:1] cfg,
                                                     input logic [2:0] ep);
    if (ep == 3'h0 || ep > EP_N)
      return usb_sr_pkg::XFER_CONTROL;
    else
      return cfg[ep].kind;
  endfunction

  // clock-gated stop keeps the engine only when firmware asked for it
  assign functional = (i_POWER_MODE == usb_sr_pkg::MODE_RUN) || (i_POWER_MODE == usb_sr_pkg::MODE_WAIT)
                      || (i_POWER_MODE == usb_sr_pkg::MODE_CLOCK_GATED_STOP && i_CLOCK_GATED_KEEP);
  assign deep_stop  = (i_POWER_MODE == usb_sr_pkg::MODE_PARTIAL_POWER_STOP)
                      || (i_POWER_MODE == usb_sr_pkg::MODE_POWER_OFF_STOP);
  // resume watch keeps running in clock-gated stop even with the engine off
  assign line_active = i_TRANSCEIVER_ENABLE && !deep_stop;
  assign clr = I_SRST || i_MODULE_RESET;

  usb_line_monitor #(
    .IDLE_CYC       (SUSPEND_IDLE_CYC)
  ) u_line (
    .i_clk          (I_CLK),
    .i_srst         (clr),
    .i_dp           (i_DATA_PLUS_LINE),
    .i_dm           (i_DATA_MINUS_LINE),
    .i_active       (line_active),
    .o_line         (line),
    .o_idle_reached (idle_reached),
    .o_bus_reset    (bus_reset),
    .o_eop          (eop)
  );

  always_comb begin
    next_idle_seen  = idle_reached;
    next_reset_seen = bus_reset;
    // set wins over firmware clear; a bus reset ends suspend
    next_suspend_flag = (idle_reached && !idle_seen) || (suspend_flag && !i_SUSPEND_CLEAR && !bus_reset);
    if (!i_RESUME_WAKE_ENABLE)
      next_resume_flag = 1'b0;
    else
      next_resume_flag = resume_flag || (suspend_flag && k_sync && !deep_stop);
    next_bus_reset_irq = functional && bus_reset && !reset_seen;
    // firmware must drop regulator and transceiver before a deep stop; flag it if not
    next_shutdown_fault = shutdown_fault || (deep_stop && (i_REGULATOR_ENABLE || i_TRANSCEIVER_ENABLE));
    next_pingpong = pingpong;
    if (functional && i_XFER_DONE && i_XFER_EP == EP_A)
      next_pingpong[0] = !pingpong[0];
    if (functional && i_XFER_DONE && i_XFER_EP == EP_B)
      next_pingpong[1] = !pingpong[1];
    next_token_type = token_type;
    if (o_TOKEN_ACCEPT)
      next_token_type = ep_kind(i_EP_CFG, i_TOKEN.ep);
  end

  always_ff @(posedge I_CLK) begin
    if (clr) begin
      idle_seen      <= 1'b0;
      reset_seen     <= 1'b0;
      suspend_flag   <= 1'b0;
      resume_flag    <= 1'b0;
      k_meta         <= 1'b0;
      k_sync         <= 1'b0;
      bus_reset_irq  <= 1'b0;
      shutdown_fault <= 1'b0;
      pingpong       <= 2'h0;
      token_type     <= usb_sr_pkg::XFER_CONTROL;
    end else begin
      idle_seen      <= next_idle_seen;
      reset_seen     <= next_reset_seen;
      suspend_flag   <= next_suspend_flag;
      resume_flag    <= next_resume_flag;
      // two stages so a k seen while clocks restart is taken exactly once
      k_meta         <= line_active && (line == usb_sr_pkg::LINE_K);
      k_sync         <= k_meta;
      bus_reset_irq  <= next_bus_reset_irq;
      shutdown_fault <= next_shutdown_fault;
      pingpong       <= next_pingpong;
      token_type     <= next_token_type;
    end
  end

  // processor wins a same-address write collision; sie write is dropped
  always_ff @(posedge I_CLK) begin
    if (i_CPU_RAM.en && i_CPU_RAM.we)
      ram[i_CPU_RAM.addr] <= i_CPU_RAM.wdata;
    if (i_SIE_RAM.en && i_SIE_RAM.we && functional && !(i_CPU_RAM.en && i_CPU_RAM.we
        && i_CPU_RAM.addr == i_SIE_RAM.addr))
      ram[i_SIE_RAM.addr] <= i_SIE_RAM.wdata;
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      cpu_rdata <= 8'h00;
      sie_rdata <= 8'h00;
    end else begin
      if (i_CPU_RAM.en && !i_CPU_RAM.we)
        cpu_rdata <= ram[i_CPU_RAM.addr];
      if (i_SIE_RAM.en && !i_SIE_RAM.we)
        sie_rdata <= ram[i_SIE_RAM.addr];
    end
  end

  assign o_TOKEN_ACCEPT         = functional && i_TOKEN.valid && ep_allowed(i_EP_CFG, i_TOKEN);
  assign o_TOKEN_TYPE           = token_type;
  assign o_PINGPONG             = pingpong;
  assign o_CPU_RDATA            = cpu_rdata;
  assign o_SIE_RDATA            = sie_rdata;
  assign o_LINE_STATE           = line;
  assign o_EOP_SEEN             = eop && functional;
  assign o_SUSPEND_IDLE_FLAG    = suspend_flag;
  assign o_LOWPOWER_RESUME_FLAG = resume_flag;
  assign o_WAKE_IRQ             = resume_flag;
  assign o_CLOCK_REQUEST        = functional || resume_flag;
  assign o_BUS_RESET_IRQ        = bus_reset_irq;
  assign o_SHUTDOWN_FAULT       = shutdown_fault;
  // remote wakeup drives k only from suspend; otherwise the pair floats when the transceiver is off
  assign o_DATA_PLUS_LINE       = 1'b0;
  assign o_DATA_MINUS_LINE      = 1'b1;
  assign o_DATA_PLUS_LINE_OE    = i_TRANSCEIVER_ENABLE && !deep_stop && suspend_flag && i_REMOTE_WAKE;
  assign o_DATA_MINUS_LINE_OE   = o_DATA_PLUS_LINE_OE;

  a_lines_float_off: assert property (@(posedge I_CLK) disable iff (I_SRST)
    !i_TRANSCEIVER_ENABLE |-> !o_DATA_PLUS_LINE_OE && !o_DATA_MINUS_LINE_OE)
    else $error("data line driven with transceiver off");

  a_resume_flag_clear: assert property (@(posedge I_CLK) disable iff (clr)
    !i_RESUME_WAKE_ENABLE |=> !o_LOWPOWER_RESUME_FLAG)
    else $error("resume flag survived wake enable clear");

  a_resume_flag_set: assert property (@(posedge I_CLK) disable iff (clr)
    i_RESUME_WAKE_ENABLE && suspend_flag && k_sync && !deep_stop |=> o_LOWPOWER_RESUME_FLAG)
    else $error("k-state while armed did not set resume flag");

  a_wake_and_clock: assert property (@(posedge I_CLK) disable iff (I_SRST)
    o_LOWPOWER_RESUME_FLAG |-> o_WAKE_IRQ && o_CLOCK_REQUEST)
    else $error("resume flag without wake and clock request");

  a_suspend_after_idle: assert property (@(posedge I_CLK) disable iff (clr)
    $rose(idle_reached) |=> o_SUSPEND_IDLE_FLAG)
    else $error("suspend flag missing after bus idle");

  a_deep_stop_dead: assert property (@(posedge I_CLK) disable iff (I_SRST)
    deep_stop |-> !o_TOKEN_ACCEPT && !o_CLOCK_REQUEST)
    else $error("engine active in deep stop");

  a_pingpong_toggle: assert property (@(posedge I_CLK) disable iff (clr)
    functional && i_XFER_DONE && i_XFER_EP == EP_A |=> o_PINGPONG[0] != $past(o_PINGPONG[0]))
    else $error("endpoint 5 buffer did not alternate");

  a_ep0_always_open: assert property (@(posedge I_CLK) disable iff (I_SRST)
    functional && i_TOKEN.valid && i_TOKEN.ep == 3'h0 |-> o_TOKEN_ACCEPT)
    else $error("endpoint 0 token refused");

  a_bus_reset_pulse: assert property (@(posedge I_CLK) disable iff (clr)
    o_BUS_RESET_IRQ |=> !o_BUS_RESET_IRQ)
    else $error("bus reset interrupt longer than one cycle");

  a_sync_two_stage: assert property (@(posedge I_CLK) disable iff (clr)
    $rose(k_meta) |=> k_sync)
    else $error("resume detect not passed through second stage");

endmodule // usb_suspend_resume

// ===== verification/usb_host_model.sv
/*
  usb host line model: puts the commanded line state on the data line pair and resolves the device's drive.
  assumes the bench changes the command just after a rising clock edge.
*/
`timescale 1ns/1ps

module usb_host_model (
  input  wire logic                    i_clk,
  input  wire usb_sr_pkg::line_state_t i_cmd,
  input  wire logic                    i_dev_dp,
  input  wire logic                    i_dev_dp_oe,
  input  wire logic                    i_dev_dm,
  input  wire logic                    i_dev_dm_oe,
  output logic                         o_dp,
  output logic                         o_dm
);
  logic host_dp;
  logic host_dm;
  // clock only marks the sampling domain; the host itself is combinational
  assign host_dp = (i_cmd == usb_sr_pkg::LINE_J) || (i_cmd == usb_sr_pkg::LINE_SE1);
  assign host_dm = (i_cmd == usb_sr_pkg::LINE_K) || (i_cmd == usb_sr_pkg::LINE_SE1);
  // device drive wins the wire only while its enable is high
  assign o_dp = i_dev_dp_oe ? i_dev_dp : host_dp;
  assign o_dm = i_dev_dm_oe ? i_dev_dm : host_dm;
endmodule // usb_host_model

// ===== verification/usb_suspend_resume_test.sv
/*
  self-checking bench for the usb suspend/resume core: idle, resume, bus reset, tokens, ping-pong, ram.
  assumes a short idle count parameter so the suspend wait stays brief.
*/
`timescale 1ns/1ps
`include "usb_sr_defs.svh"

module usb_suspend_resume_test;
  localparam int unsigned IDLE_CYC = 40;
  logic I_CLK, I_SRST, i_MODULE_RESET, i_CLOCK_GATED_KEEP, i_TRANSCEIVER_ENABLE, i_REGULATOR_ENABLE;
  logic i_RESUME_WAKE_ENABLE, i_SUSPEND_CLEAR, i_REMOTE_WAKE, i_DATA_PLUS_LINE, i_DATA_MINUS_LINE, i_XFER_DONE;
  logic o_DATA_PLUS_LINE, o_DATA_PLUS_LINE_OE, o_DATA_MINUS_LINE, o_DATA_MINUS_LINE_OE, o_EOP_SEEN;
  logic o_SUSPEND_IDLE_FLAG, o_LOWPOWER_RESUME_FLAG, o_WAKE_IRQ, o_CLOCK_REQUEST, o_BUS_RESET_IRQ;
  logic o_SHUTDOWN_FAULT, o_TOKEN_ACCEPT;
  logic [2:0]                       i_XFER_EP;
  logic [1:0]                       o_PINGPONG;
  logic [7:0]                       o_CPU_RDATA, o_SIE_RDATA;
  usb_sr_pkg::power_mode_t          i_POWER_MODE;
  usb_sr_pkg::line_state_t          o_LINE_STATE, host_cmd;
  usb_sr_pkg::xfer_type_t           o_TOKEN_TYPE;
  usb_sr_pkg::ep_cfg_t [`EP_LAST:1] i_EP_CFG;
  usb_sr_pkg::token_t               i_TOKEN;
  usb_sr_pkg::ram_req_t             i_CPU_RAM, i_SIE_RAM;
  int                               mismatches, total_checks, n, m;
  logic [2:0]                       tok_ep  [7] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  logic                             tok_dir [7] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  logic                             tok_acc [7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  usb_sr_pkg::xfer_type_t           tok_ty  [7] = '{usb_sr_pkg::XFER_CONTROL, usb_sr_pkg::XFER_BULK,
    usb_sr_pkg::XFER_BULK, usb_sr_pkg::XFER_BULK, usb_sr_pkg::XFER_ISOCHRONOUS, usb_sr_pkg::XFER_INTERRUPT,
    usb_sr_pkg::XFER_INTERRUPT};
  logic [2:0]                       pp_ep   [4] = '{3'h5, 3'h6, 3'h5, 3'h4};
  logic [1:0]                       pp_exp  [4] = '{2'h1, 2'h3, 2'h2, 2'h2};

  usb_suspend_resume #(.SUSPEND_IDLE_CYC(IDLE_CYC)) u_dut (.*);

  usb_host_model u_host (
    .i_clk       (I_CLK),
    .i_cmd       (host_cmd),
    .i_dev_dp    (o_DATA_PLUS_LINE),
    .i_dev_dp_oe (o_DATA_PLUS_LINE_OE),
    .i_dev_dm    (o_DATA_MINUS_LINE),
    .i_dev_dm_oe (o_DATA_MINUS_LINE_OE),
    .o_dp        (i_DATA_PLUS_LINE),
    .o_dm        (i_DATA_MINUS_LINE)
  );

  always #10 I_CLK = ~I_CLK;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // 0 suspend, 1 resume, 2 bus reset, 3 end of packet
  function automatic logic pick(input int sel);
    case (sel)
      0: return o_SUSPEND_IDLE_FLAG;
      1: return o_LOWPOWER_RESUME_FLAG;
      2: return o_BUS_RESET_IRQ;
      default: return o_EOP_SEEN;
    endcase
  endfunction

  // a wait that runs out ends the run rather than hanging
  task automatic wait_hi(input string what, input int sel, input int lim, output int cnt);
    for (cnt = 1; cnt <= lim; cnt++) begin
      @(posedge I_CLK);
      #1;
      if (pick(sel) === 1'b1) return;
    end
    mismatches++;
    $display("[ERR] %s expected 1 seen timeout", what);
    final_report();
  endtask

  initial begin
    I_CLK = 0; I_SRST = 1; i_MODULE_RESET = 0; i_CLOCK_GATED_KEEP = 0; i_TRANSCEIVER_ENABLE = 0;
    i_REGULATOR_ENABLE = 0; i_RESUME_WAKE_ENABLE = 0; i_SUSPEND_CLEAR = 0; i_REMOTE_WAKE = 0;
    i_XFER_DONE = 0; i_XFER_EP = 3'h0; i_POWER_MODE = usb_sr_pkg::MODE_RUN; host_cmd = usb_sr_pkg::LINE_J;
    i_TOKEN = '0; i_CPU_RAM = '0; i_SIE_RAM = '0; mismatches = 0; total_checks = 0;
    i_EP_CFG[1] = '{1'b1, 1'b1, usb_sr_pkg::XFER_BULK};
    i_EP_CFG[2] = '{1'b0, 1'b0, usb_sr_pkg::XFER_INTERRUPT};
    i_EP_CFG[3] = '{1'b1, 1'b0, usb_sr_pkg::XFER_ISOCHRONOUS};
    for (int e = 4; e <= `EP_LAST; e++) i_EP_CFG[e] = '{1'b1, 1'b0, usb_sr_pkg::XFER_INTERRUPT};
    repeat (5) @(posedge I_CLK);
    I_SRST <= 0;
    #1 chk("line_oe", 2'b00, {o_DATA_PLUS_LINE_OE, o_DATA_MINUS_LINE_OE});
    chk("flags", 3'b000, {o_SUSPEND_IDLE_FLAG, o_LOWPOWER_RESUME_FLAG, o_SHUTDOWN_FAULT});
    // transceiver off: idle lines must not count towards suspend
    repeat (IDLE_CYC + 20) @(posedge I_CLK);
    #1 chk("suspend_line_transceiver_off", 1'b0, o_SUSPEND_IDLE_FLAG);
    @(posedge I_CLK);
    i_TRANSCEIVER_ENABLE <= 1;
    i_REGULATOR_ENABLE <= 1;
    host_cmd <= usb_sr_pkg::LINE_SE0;
    repeat (3) @(posedge I_CLK);
    host_cmd <= usb_sr_pkg::LINE_J;
    wait_hi("eop", 3, 6, n);
    chk("line_state", usb_sr_pkg::LINE_J, o_LINE_STATE);
    wait_hi("suspend", 0, IDLE_CYC + 20, m);
    chk("suspend_time", 1'b1, (n + m >= IDLE_CYC - 1) && (n + m <= IDLE_CYC + 6));
    // remote wake drives k, which must not wake while the resume enable is clear
    @(posedge I_CLK);
    i_REMOTE_WAKE <= 1;
    #1 chk("remote_k", 4'b1101, {o_DATA_PLUS_LINE_OE, o_DATA_MINUS_LINE_OE, i_DATA_PLUS_LINE, i_DATA_MINUS_LINE});
    repeat (6) @(posedge I_CLK);
    i_REMOTE_WAKE <= 0;
    #1 chk("resume_no_enable", 1'b0, o_LOWPOWER_RESUME_FLAG);
    // our own k must drain through the two sync stages before arming, or it wakes us at once
    repeat (3) @(posedge I_CLK);
    i_RESUME_WAKE_ENABLE <= 1;
    i_POWER_MODE <= usb_sr_pkg::MODE_CLOCK_GATED_STOP;
    i_TOKEN <= '{1'b1, 3'h0, 1'b0};
    #1 chk("token_gated_stop", 1'b0, o_TOKEN_ACCEPT);
    @(posedge I_CLK);
    i_TOKEN <= '0;
    host_cmd <= usb_sr_pkg::LINE_K;
    wait_hi("resume", 1, 8, n);
    chk("resume_sync", 1'b1, n >= 4 && n <= 6);
    chk("wake_clock", 2'b11, {o_WAKE_IRQ, o_CLOCK_REQUEST});
    @(posedge I_CLK);
    i_RESUME_WAKE_ENABLE <= 0;
    i_POWER_MODE <= usb_sr_pkg::MODE_RUN;
    host_cmd <= usb_sr_pkg::LINE_J;
    @(posedge I_CLK);
    #1 chk("resume_cleared", 2'b00, {o_LOWPOWER_RESUME_FLAG, o_WAKE_IRQ});
    @(posedge I_CLK);
    host_cmd <= usb_sr_pkg::LINE_SE0;
    wait_hi("bus_reset", 2, 200, n);
    chk("bus_reset_time", 1'b1, n >= 125 && n <= 130);
    @(posedge I_CLK);
    host_cmd <= usb_sr_pkg::LINE_J;
    #1 chk("bus_reset_pulse", 2'b00, {o_BUS_RESET_IRQ, o_SUSPEND_IDLE_FLAG});
    // back-to-back tokens in wait mode; type lands one edge after acceptance
    @(posedge I_CLK);
    i_POWER_MODE <= usb_sr_pkg::MODE_WAIT;
    for (int k = 0; k < 7; k++) begin
      @(posedge I_CLK);
      i_TOKEN <= '{1'b1, tok_ep[k], tok_dir[k]};
      #1 chk("token_accept", tok_acc[k], o_TOKEN_ACCEPT);
      if (k > 0 && tok_acc[k-1]) chk("token_type", tok_ty[k-1], o_TOKEN_TYPE);
    end
    @(posedge I_CLK);
    i_POWER_MODE <= usb_sr_pkg::MODE_CLOCK_GATED_STOP;
    i_CLOCK_GATED_KEEP <= 1;
    i_TOKEN <= '{1'b1, 3'h0, 1'b0};
    #1 chk("token_gated_keep", 1'b1, o_TOKEN_ACCEPT);
    @(posedge I_CLK);
    i_POWER_MODE <= usb_sr_pkg::MODE_PARTIAL_POWER_STOP;
    i_TOKEN <= '{1'b1, 3'h0, 1'b0};
    #1 chk("token_deep_stop", 1'b0, o_TOKEN_ACCEPT);
    repeat (2) @(posedge I_CLK);
    i_TOKEN <= '0;
    i_POWER_MODE <= usb_sr_pkg::MODE_RUN;
    #1 chk("shutdown_fault", 1'b1, o_SHUTDOWN_FAULT);
    @(posedge I_CLK);
    I_SRST <= 1;
    repeat (2) @(posedge I_CLK);
    I_SRST <= 0;
    #1 chk("fault_after_reset", 1'b0, o_SHUTDOWN_FAULT);
    for (int k = 0; k < 4; k++) begin
      @(posedge I_CLK);
      i_XFER_DONE <= 1;
      i_XFER_EP <= pp_ep[k];
      @(posedge I_CLK);
      i_XFER_DONE <= 0;
      #1 chk("pingpong", pp_exp[k], o_PINGPONG);
    end
    // ram contents survive a module reset, ping-pong state does not
    @(posedge I_CLK);
    i_CPU_RAM <= '{1'b1, 1'b1, 8'hFF, 8'hA5};
    i_SIE_RAM <= '{1'b1, 1'b1, 8'h00, 8'h3C};
    i_MODULE_RESET <= 1;
    @(posedge I_CLK);
    i_MODULE_RESET <= 0;
    i_CPU_RAM <= '{1'b1, 1'b0, 8'h00, 8'h00};
    i_SIE_RAM <= '{1'b1, 1'b0, 8'hFF, 8'h00};
    #1 chk("pingpong_reset", 2'b00, o_PINGPONG);
    @(posedge I_CLK);
    i_CPU_RAM <= '0;
    i_SIE_RAM <= '0;
    #1 chk("ram_cross", 16'h3CA5, {o_CPU_RDATA, o_SIE_RDATA});
    // idle again after the module reset; firmware clear must drop the flag
    wait_hi("suspend_again", 0, IDLE_CYC + 20, n);
    @(posedge I_CLK);
    i_SUSPEND_CLEAR <= 1;
    @(posedge I_CLK);
    i_SUSPEND_CLEAR <= 0;
    #1 chk("suspend_clear", 1'b0, o_SUSPEND_IDLE_FLAG);
    final_report();
  end
endmodule // usb_suspend_resume_test
